// ===== slt_cmp_model.sv
// comparator model for the trigger inputs
module slt_cmp_model (
    // channel levels
    input  wire logic [31:0]       ana,
    input  wire slt_pkg::slt_thr_t dac,
    input  wire logic [1:0]        src_sel,
    // comparator flags, sample
    output slt_pkg::slt_cmp_t      cmp,
    output logic [7:0]             smp
);
    timeunit 1ns / 1ps;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp.level[i] = ana[8*i +: 8] > dac.level;
            cmp.upper[i] = ana[8*i +: 8] > dac.upper;
            cmp.lower[i] = ana[8*i +: 8] > dac.lower;
        end
    end
    assign smp = ana[8*src_sel +: 8];
endmodule // slt_cmp_model

// ===== slt_div.sv
// sequential restoring divider, one quotient bit per clock
module slt_div (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // operands
    input  wire logic        start,
    input  wire logic [15:0] num,
    input  wire logic [23:0] den,
    // result
    output logic             busy,
    output logic      [15:0] quo
);
    logic [24:0] rem;
    logic [24:0] trial;
    logic [15:0] nsh;
    logic [4:0]  cnt;

    assign trial = {rem[23:0], nsh[15]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem  <= '0;
            nsh  <= '0;
            quo  <= '0;
            cnt  <= '0;
            busy <= 1'b0;
        end else if (ce) begin
            if (start) begin
                rem  <= '0;
                nsh  <= num;
                quo  <= '0;
                cnt  <= 5'h10;
                busy <= 1'b1;
            end else if (busy) begin
                // a zero divisor saturates the quotient to all ones
                if (trial >= {1'b0, den}) begin
                    rem <= trial - {1'b0, den};
                    quo <= {quo[14:0], 1'b1};
                end else begin
                    rem <= trial;
                    quo <= {quo[14:0], 1'b0};
                end
                nsh  <= {nsh[14:0], 1'b0};
                cnt  <= cnt - 5'h01;
                busy <= (cnt != 5'h01);
            end
        end
    end
endmodule // slt_div

// ===== slt_pkg.sv
// shared constants, types and register map of the slew/timeout trigger
package slt_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 40000;
    localparam int TRANSIT_MIN_PS  = 600;
    localparam int TRANSIT_MIN_CYC =
        (TRANSIT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_MIN_PS    = 7500;
    localparam int SEARCH_US       = 100;
    localparam int SEARCH_CYC      = SEARCH_US * 1000000 / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_THRESH   = 8'h04;
    localparam logic [7:0] OFS_DELTA    = 8'h08;
    localparam logic [7:0] OFS_TIMEOUT  = 8'h0c;
    localparam logic [7:0] OFS_PRESET   = 8'h10;
    localparam logic [7:0] OFS_RATE     = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    localparam logic [7:0] OFS_MEAS     = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PRE_TTL_BIT  = 0;
    localparam int PRE_ECL_BIT  = 1;
    localparam int PRE_HALF_BIT = 2;
    localparam int IRQ_SLEW_BIT = 0;
    localparam int IRQ_TMO_BIT  = 1;
    localparam int IRQ_SRCH_BIT = 2;
    localparam logic [23:0] RST_DELTA   = 24'h000010;
    localparam logic [23:0] RST_TIMEOUT = 24'h000100;
    localparam logic [7:0]  RST_UPPER   = 8'hc0;
    localparam logic [7:0]  RST_LOWER   = 8'h40;
    localparam logic [7:0]  RST_LEVEL   = 8'h80;
    localparam logic [7:0]  TTL_UPPER   = 8'ha0;
    localparam logic [7:0]  TTL_LOWER   = 8'h60;
    localparam logic [7:0]  ECL_UPPER   = 8'h70;
    localparam logic [7:0]  ECL_LOWER   = 8'h50;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SLT_SPOL_POS    = 2'b00,
        SLT_SPOL_NEG    = 2'b01,
        SLT_SPOL_EITHER = 2'b10
    } slt_spol_t;

    typedef enum logic [1:0] {
        SLT_TPOL_HIGH   = 2'b00,
        SLT_TPOL_LOW    = 2'b01,
        SLT_TPOL_EITHER = 2'b10
    } slt_tpol_t;

    typedef enum logic [1:0] {
        SLT_ST_WAIT = 2'b00,
        SLT_ST_RISE = 2'b01,
        SLT_ST_FALL = 2'b10
    } slt_state_t;

    typedef struct packed {
        slt_tpol_t  tpol;
        logic       slow;
        slt_spol_t  spol;
        logic [1:0] src;
        logic       tmo_class;
        logic       en;
    } slt_ctrl_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] upper;
        logic [7:0] lower;
    } slt_thr_t;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] upper;
        logic [3:0] lower;
    } slt_cmp_t;

endpackage

// ===== slt_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
module slt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // slt_sync

// ===== slt_trigger.sv
// slew rate and timeout pulse trigger qualifier with apb registers
//
// Behaviour
// [RULE1] slew class triggers on faster/slower edges
// [RULE2] positive polarity: lower then upper crossing
// [RULE3] negative polarity: upper then lower crossing
// [RULE4] either polarity accepts both edge directions
// [RULE5] compare transit count against delta time
// [RULE6] slew rate readout recomputed, never written
// [RULE7] sense bit picks faster or slower edges
// [RULE8] sub-600 ps transits need not trigger
// [RULE9] source pulses must be 7.5 ns wide
// [RULE10] trigger at the last threshold crossed
// [RULE11] ttl/ecl presets load both thresholds
// [RULE12] one shared source among four channels
// [RULE13] timeout class triggers on missing change
// [RULE14] stays high triggers after timeout above
// [RULE15] stays low triggers after timeout below
// [RULE16] either triggers on staying high or low
// [RULE17] halfway preset sets level between peaks
// [RULE18] sampled comparators, durations counted in clocks
//
// Our own choices: the register addresses and the APB interface to the registers.
module slt_trigger (
    // apb
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // clock enable
    input  wire logic              ce,
    // comparator front end
    input  wire slt_pkg::slt_cmp_t cmp,
    input  wire logic [7:0]        src_sample,
    // threshold dacs and trigger
    output slt_pkg::slt_thr_t      dac,
    output logic      [1:0]        src_sel,
    output logic                   trig_out,
    output logic                   trig_class,
    output logic                   irq
);
    import slt_pkg::*;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    slt_ctrl_t   ctrl;
    logic [23:0] delta;
    logic [23:0] tmo_val;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic [23:0] meas;
    logic        wr;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_thr;
    logic        wr_delta;
    logic        wr_pre;
    logic        wr_clr;
    logic [31:0] rd_mux;

    always_comb begin
        if (paddr == OFS_CTRL || paddr == OFS_THRESH ||
            paddr == OFS_DELTA || paddr == OFS_TIMEOUT ||
            paddr == OFS_PRESET || paddr == OFS_RATE ||
            paddr == OFS_STATUS || paddr == OFS_MEAS ||
            paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_EN ||
            paddr == OFS_IRQ_CLR) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr       = psel && penable && pwrite && mapped;
    assign wr_ctrl  = wr && paddr == OFS_CTRL;
    assign wr_thr   = wr && paddr == OFS_THRESH;
    assign wr_delta = wr && paddr == OFS_DELTA;
    assign wr_pre   = wr && paddr == OFS_PRESET;
    assign wr_clr   = wr && paddr == OFS_IRQ_CLR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= '0;
            delta   <= RST_DELTA;
            tmo_val <= RST_TIMEOUT;
            irq_en  <= '0;
        end else if (ce && wr) begin
            if (paddr == OFS_CTRL) begin
                ctrl <= slt_ctrl_t'(pwdata[8:0]);
            end else if (paddr == OFS_DELTA) begin
                delta <= pwdata[23:0];
            end else if (paddr == OFS_TIMEOUT) begin
                tmo_val <= pwdata[23:0];
            end else if (paddr == OFS_IRQ_EN) begin
                irq_en <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // comparator sampling and source select
    // ------------------------------------------------------------
    slt_cmp_t   cmp_s;
    logic [7:0] sample_s;
    logic       u_s;
    logic       l_s;
    logic       lvl_s;
    logic       u_p;
    logic       l_p;
    logic       lvl_p;

    slt_sync #(.W(12)) u_cmp_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .d     (cmp),
        .q     (cmp_s)
    );

    slt_sync #(.W(8)) u_smp_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .d     (src_sample),
        .q     (sample_s)
    );

    assign src_sel = ctrl.src;                           // RULE12
    assign u_s     = cmp_s.upper[ctrl.src];              // RULE12
    assign l_s     = cmp_s.lower[ctrl.src];              // RULE18
    assign lvl_s   = cmp_s.level[ctrl.src];              // RULE18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            u_p   <= 1'b0;
            l_p   <= 1'b0;
            lvl_p <= 1'b0;
        end else if (ce) begin
            u_p   <= u_s;
            l_p   <= l_s;
            lvl_p <= lvl_s;
        end
    end

    // ------------------------------------------------------------
    // slew rate transit measurement
    // ------------------------------------------------------------
    slt_state_t  st;
    logic [23:0] cnt;
    logic        rise_ok;
    logic        fall_ok;
    logic        at_last;
    logic        speed_ok;
    logic        slew_hit;

    assign rise_ok = ctrl.spol != SLT_SPOL_NEG;          // RULE2 RULE4
    assign fall_ok = ctrl.spol != SLT_SPOL_POS;          // RULE3 RULE4
    // edge ends where the far threshold is crossed
    assign at_last = (st == SLT_ST_RISE && u_s) ||
                     (st == SLT_ST_FALL && !l_s && !u_s); // RULE10
    assign speed_ok = ctrl.slow ? (cnt > delta)
                                : (cnt < delta);          // RULE5 RULE7
    assign slew_hit = ce && ctrl.en && !ctrl.tmo_class && at_last &&
                      speed_ok &&
                      cnt >= 24'(TRANSIT_MIN_CYC);        // RULE1 RULE8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st  <= SLT_ST_WAIT;
            cnt <= '0;
        end else if (ce) begin
            if (wr_ctrl) begin
                st <= SLT_ST_WAIT;
            end else begin
                case (st)
                    SLT_ST_WAIT: begin
                        // jumps over both thresholds in one sample skip
                        if (!l_p && l_s && !u_s && rise_ok) begin
                            st  <= SLT_ST_RISE;                  // RULE2
                            cnt <= 24'h000001;
                        end else if (u_p && !u_s && l_s && fall_ok) begin
                            st  <= SLT_ST_FALL;                  // RULE3
                            cnt <= 24'h000001;
                        end
                    end
                    SLT_ST_RISE: begin
                        if (u_s || !l_s) begin
                            st <= SLT_ST_WAIT;
                        end else if (cnt != 24'hffffff) begin
                            cnt <= cnt + 24'h000001;             // RULE18
                        end
                    end
                    SLT_ST_FALL: begin
                        if (!l_s || u_s) begin
                            st <= SLT_ST_WAIT;
                        end else if (cnt != 24'hffffff) begin
                            cnt <= cnt + 24'h000001;             // RULE18
                        end
                    end
                    default: st <= SLT_ST_WAIT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // timeout measurement
    // ------------------------------------------------------------
    logic [23:0] to_cnt;
    logic        to_done;
    logic        to_pol_ok;
    logic        to_hit;

    assign to_pol_ok = (ctrl.tpol == SLT_TPOL_HIGH && lvl_s) ||
                       (ctrl.tpol == SLT_TPOL_LOW && !lvl_s) ||
                       ctrl.tpol == SLT_TPOL_EITHER;   // RULE14 RULE15 RULE16
    assign to_hit = ce && ctrl.en && ctrl.tmo_class && !to_done &&
                    lvl_s == lvl_p && to_cnt == tmo_val &&
                    to_pol_ok;                         // RULE13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_cnt  <= '0;
            to_done <= 1'b0;
        end else if (ce) begin
            if (lvl_s != lvl_p || wr_ctrl) begin
                to_cnt  <= '0;
                to_done <= 1'b0;
            end else if (to_hit) begin
                to_done <= 1'b1;                       // one trigger per stay
            end else if (!to_done && to_cnt != 24'hffffff) begin
                to_cnt <= to_cnt + 24'h000001;         // RULE18
            end
        end
    end

    // ------------------------------------------------------------
    // thresholds, presets and halfway search
    // ------------------------------------------------------------
    logic        srch_busy;
    logic        srch_done;
    logic [11:0] srch_cnt;
    logic [7:0]  smin;
    logic [7:0]  smax;
    logic [8:0]  ssum;

    assign ssum      = {1'b0, smin} + {1'b0, smax};
    assign srch_done = ce && srch_busy &&
                       srch_cnt == 12'(SEARCH_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srch_busy <= 1'b0;
            srch_cnt  <= '0;
            smin      <= 8'hff;
            smax      <= 8'h00;
        end else if (ce) begin
            if (wr_pre && pwdata[PRE_HALF_BIT]) begin
                srch_busy <= 1'b1;
                srch_cnt  <= '0;
                smin      <= 8'hff;
                smax      <= 8'h00;
            end else if (srch_busy) begin
                if (sample_s < smin) begin
                    smin <= sample_s;                  // RULE17
                end
                if (sample_s > smax) begin
                    smax <= sample_s;                  // RULE17
                end
                srch_cnt  <= srch_cnt + 12'h001;
                srch_busy <= !srch_done;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac <= {RST_LEVEL, RST_UPPER, RST_LOWER};
        end else if (ce) begin
            if (wr_thr) begin
                dac <= slt_thr_t'(pwdata[23:0]);
            end else if (wr_pre && pwdata[PRE_TTL_BIT]) begin
                dac.upper <= TTL_UPPER;                // RULE11
                dac.lower <= TTL_LOWER;                // RULE11
            end else if (wr_pre && pwdata[PRE_ECL_BIT]) begin
                dac.upper <= ECL_UPPER;                // RULE11
                dac.lower <= ECL_LOWER;                // RULE11
            end else if (srch_done) begin
                dac.level <= ssum[8:1];                // RULE17
            end
        end
    end

    // ------------------------------------------------------------
    // slew rate readout
    // ------------------------------------------------------------
    logic        rate_kick;
    logic        rate_busy;
    logic [15:0] rate;
    logic [7:0]  dv;

    assign dv = (dac.upper > dac.lower) ? dac.upper - dac.lower : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_kick <= 1'b1;
        end else if (ce) begin
            rate_kick <= wr_thr || wr_delta || wr_pre;     // RULE6
        end
    end

    slt_div u_rate_div (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .start (rate_kick),
        .num   ({dv, 8'h00}),
        .den   (delta),
        .busy  (rate_busy),
        .quo   (rate)
    );

    // ------------------------------------------------------------
    // trigger outputs, measurement, interrupts, read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_out   <= 1'b0;
            trig_class <= 1'b0;
            meas       <= '0;
        end else if (ce) begin
            trig_out   <= slew_hit || to_hit;              // RULE10
            trig_class <= to_hit;
            if (at_last) begin
                meas <= cnt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (ce) begin
            // a new event wins over a clear in the same cycle
            irq_stat <= (irq_stat & ~(wr_clr ? pwdata[2:0] : 3'h0)) |
                        {srch_done, to_hit, slew_hit};
        end
    end

    assign irq = |(irq_stat & irq_en);

    always_comb begin
        if (paddr == OFS_CTRL) begin
            rd_mux = {23'h000000, ctrl};
        end else if (paddr == OFS_THRESH) begin
            rd_mux = {8'h00, dac};
        end else if (paddr == OFS_DELTA) begin
            rd_mux = {8'h00, delta};
        end else if (paddr == OFS_TIMEOUT) begin
            rd_mux = {8'h00, tmo_val};
        end else if (paddr == OFS_RATE) begin
            rd_mux = {rate_busy, 15'h0000, rate};          // RULE6
        end else if (paddr == OFS_STATUS) begin
            rd_mux = {27'h0000000, srch_busy, rate_busy, st, lvl_s};
        end else if (paddr == OFS_MEAS) begin
            rd_mux = {8'h00, meas};
        end else if (paddr == OFS_IRQ_STAT) begin
            rd_mux = {29'h00000000, irq_stat};
        end else if (paddr == OFS_IRQ_EN) begin
            rd_mux = {29'h00000000, irq_en};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    rise_needs_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        st == SLT_ST_RISE |-> ctrl.spol != SLT_SPOL_NEG) // RULE2
        else $error("rising transit with negative polarity");
    fall_needs_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        st == SLT_ST_FALL |-> ctrl.spol != SLT_SPOL_POS) // RULE3
        else $error("falling transit with positive polarity");
    slew_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
        slew_hit |-> (ctrl.slow ? cnt > delta : cnt < delta)) // RULE7
        else $error("slew trigger against sense");
    slew_point_a: assert property (@(posedge pclk) disable iff (!presetn)
        slew_hit |-> (st == SLT_ST_RISE ? u_s : !l_s)
        ##1 trig_out && !trig_class) // RULE10
        else $error("slew trigger not at last crossing");
    stay_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        to_hit && ctrl.tpol == SLT_TPOL_HIGH |->
        lvl_s && $past(lvl_s) && to_cnt == tmo_val) // RULE14
        else $error("stays high trigger while low");
    stay_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        to_hit && ctrl.tpol == SLT_TPOL_LOW |->
        !lvl_s ##1 trig_out && trig_class) // RULE15
        else $error("stays low trigger while high");
    rate_recalc_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr_delta ##1 ce |=> rate_busy) // RULE6
        else $error("rate not recomputed after delta write");
    ttl_preset_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr_pre && pwdata[PRE_TTL_BIT] && !wr_thr |=>
        dac.upper == TTL_UPPER && dac.lower == TTL_LOWER) // RULE11
        else $error("ttl preset not loaded");
    halfway_a: assert property (@(posedge pclk) disable iff (!presetn)
        srch_done && !wr_thr && !wr_pre |=>
        dac.level == $past(ssum[8:1]) && !srch_busy) // RULE17
        else $error("halfway level wrong");
endmodule // slt_trigger

// ===== testbench.sv
// apb bench for the slew and timeout trigger
module testbench;
    timeunit 1ns / 1ps;
    import slt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        trig_out, trig_class, irq, err, cls;
    logic [7:0]  paddr, smp;
    logic [31:0] pwdata, prdata, ana, rd;
    logic [1:0]  src_sel;
    slt_cmp_t    cmp;
    slt_thr_t    dac;
    int          failures, checks, trigs;
    slt_trigger i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ce(1'b1), .cmp,
        .src_sample(smp), .dac, .src_sel, .trig_out, .trig_class, .irq);
    slt_cmp_model i_cmp (.ana, .dac, .src_sel, .cmp, .smp);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (trig_out === 1'b1)
            {trigs, cls} <= {trigs + 1, trig_class};
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic run(logic [7:0] a, b, int n, h, logic [31:0] e);
        int t0 = trigs;
        ana[23:16] <= a;
        repeat (4) @(posedge pclk);
        if (n > 0) ana[23:16] <= 8'h80;
        repeat (n) @(posedge pclk);
        ana[23:16] <= b;
        repeat (h) @(posedge pclk);
        chk(trigs - t0, e);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ana} = '0;
        {failures, checks, trigs, cls} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_THRESH, 0);
        chk(rd, {8'h00, RST_LEVEL, RST_UPPER, RST_LOWER});
        apb(1, OFS_DELTA, {8'h00, RST_DELTA});
        repeat (20) @(posedge pclk);
        apb(0, OFS_RATE, 0);
        chk(rd, 32'h800);
        apb(0, 8'h3c, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1, OFS_IRQ_EN, 3);
        for (int p = 0; p < 3; p++) begin
            apb(1, OFS_CTRL, 32'h9 | (p << 4));
            run(8'h00, 8'hff, 4, 6, p != 1);
            run(8'hff, 8'h00, 4, 6, p != 0);
        end
        chk(src_sel, 2'd2);
        chk(irq, 1'b1);
        apb(1, OFS_IRQ_CLR, 3);
        @(posedge pclk);
        chk(irq, 1'b0);
        for (int s = 0; s < 2; s++) begin
            apb(1, OFS_CTRL, 32'h9 | (s << 6));
            run(8'h00, 8'hff, 4, 6, s == 0);
            run(8'h00, 8'hff, 24, 6, s);
            run(8'h00, 8'hff, 0, 6, 0);
        end
        apb(0, OFS_MEAS, 0);
        chk(rd, 32'h18);
        apb(1, OFS_PRESET, 1);
        apb(0, OFS_THRESH, 0);
        chk(rd[15:0], {TTL_UPPER, TTL_LOWER});
        repeat (20) @(posedge pclk);
        apb(0, OFS_RATE, 0);
        chk(rd, 32'h400);
        apb(1, OFS_PRESET, 2);
        apb(1, OFS_TIMEOUT, 8);
        chk(dac[15:0], {ECL_UPPER, ECL_LOWER});
        for (int t = 0; t < 3; t++) begin
            apb(1, OFS_CTRL, 32'hb | (t << 7));
            run(8'h00, 8'hff, 0, 24, t != 1);
            run(8'hff, 8'h00, 0, 24, t != 0);
        end
        chk(cls, 1'b1);
        ana[23:16] <= 8'h10;
        apb(1, OFS_PRESET, 4);
        repeat (100) @(posedge pclk);
        ana[23:16] <= 8'h30;
        repeat (2500) @(posedge pclk);
        apb(0, OFS_THRESH, 0);
        chk(rd[23:16], 8'h20);
        apb(0, OFS_IRQ_STAT, 0);
        chk(rd, 32'h7);
        conclude();
    end
endmodule // testbench
